// file: fsol_pkg.sv
package fsol_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_OPT    = 16'h1821;
  localparam logic [15:0] IDX_STAT   = 16'h1827;
  localparam logic [15:0] IDX_CFG    = 16'h1823;
  localparam logic [15:0] IDX_PROT   = 16'h1824;
  localparam logic [15:0] IDX_KEY    = 16'hffb0;
  localparam logic [15:0] IDX_NONVOLATILE_PROTECT_BYTE = 16'hffbd;
  localparam logic [15:0] IDX_NONVOLATILE_OPTION_BYTE  = 16'hffbf;
  localparam int          KEY_BYTES  = 8;
  localparam int          ADDR_W     = 18;
  // Option byte fields
  localparam int          KEY_ENABLE_POS = 7;
  localparam int          REDIRECT_POS   = 6;
  localparam int          SEC_HI_POS     = 1;
  localparam int          SEC_LO_POS     = 0;
  localparam logic [1:0]  SEC_UNSECURED  = 2'h2;
  localparam logic [7:0]  OPT_USED_MASK  = 8'hc3;
  // Config byte field
  localparam int          KEY_ACCESS_POS = 5;
  // Status fields
  localparam int          ST_SEC_POS  = 0;
  localparam int          ST_BKD_POS  = 1;
  localparam int          ST_ERS_POS  = 2;
  // Reset values until the load from flash lands
  localparam logic [7:0]  WORK_RST   = 8'hff;
  localparam logic [63:0] KEY_RST    = 64'hffffffffffffffff;

  typedef struct packed {
    logic [63:0] key;
    logic [7:0]  prot;
    logic [7:0]  opt;
  } fsol_nv_t;

  typedef struct packed {
    logic secured;
    logic ram_access_ok;
    logic vector_redirect_disable;
    logic [7:0] flash_protect;
  } fsol_status_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01,
    ST_CMP  = 2'b11
  } fsol_state_t;
endpackage : fsol_pkg

// file: fsol_loader.sv
`timescale 1ns/1ns
//Behaviour
// [RULE1] Every reset copies nonvolatile protect and option bytes into working registers.
// [RULE2] An eight-byte backdoor compare key is held from the flash nonvolatile area.
// [RULE3] The key may unsecure memory only while the key-enable bit reads one.
// [RULE4] Key presentation accepted only from code running in secure memory.
// [RULE5] Background debug can never enter the key or start a compare.
// [RULE6] Key-enable programmed to zero disables the backdoor completely.
// [RULE7] Without key, only mass erase plus blank verify unsecures memory.
// [RULE8] Security code one-zero means unsecured after reset.
// [RULE9] While secured, RAM is closed to debug and non-secure code.
// [RULE10] Every other security code value means secured.
module fsol_loader
  import fsol_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire fsol_nv_t          nv,
  input  wire logic              bdm_master,
  input  wire logic              code_secure,
  input  wire logic              erase_blank_ok,
  output fsol_status_t           status
);
  fsol_state_t state;
  fsol_state_t next_state;
  logic [7:0]  opt_w;
  logic [7:0]  next_opt_w;
  logic [7:0]  prot_w;
  logic [7:0]  next_prot_w;
  logic [63:0] key_w;
  logic [63:0] next_key_w;
  logic [63:0] entered;
  logic [63:0] next_entered;
  logic [7:0]  got;
  logic [7:0]  next_got;
  logic        key_access;
  logic        next_key_access;
  logic        bkd_unlock;
  logic        next_bkd_unlock;
  logic        ers_unlock;
  logic        next_ers_unlock;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        rerr;
  logic        next_rerr;

  logic [15:0] idx;
  logic        setup;
  logic        wr;
  logic        key_en;
  logic        secured;
  logic        key_src_ok;
  logic        key_hit;
  logic [2:0]  key_sel;

  function automatic logic is_key(input logic [15:0] i);
    is_key = (i >= IDX_KEY) && (i < IDX_KEY + 16'(KEY_BYTES));
  endfunction : is_key

  function automatic logic is_read_only(input logic [15:0] i);
    is_read_only = (i == IDX_OPT) || (i == IDX_STAT) ||
                   (i == IDX_NONVOLATILE_PROTECT_BYTE) || (i == IDX_NONVOLATILE_OPTION_BYTE);
  endfunction : is_read_only

  function automatic logic is_mapped(input logic [15:0] i);
    is_mapped = (i == IDX_CFG) || (i == IDX_PROT) || is_read_only(i) || is_key(i);
  endfunction : is_mapped

  assign idx        = paddr[ADDR_W-1:2];
  assign setup      = psel && !penable;
  assign wr         = psel && penable && pwrite && !rerr;
  assign key_en     = opt_w[KEY_ENABLE_POS];
  // Only secure-memory code, never the debug master, reaches the key
  assign key_src_ok = code_secure && !bdm_master; // [RULE4] [RULE5]
  assign key_hit    = is_key(idx);
  assign key_sel    = idx[2:0];
  // Unsecured code or a temporary unlock; anything else stays secured
  assign secured    = (state != ST_RUN && state != ST_CMP) ||
                      !((opt_w[SEC_HI_POS:SEC_LO_POS] == SEC_UNSECURED) ||
                        bkd_unlock || ers_unlock); // [RULE8] [RULE10]

  assign pready  = 1'b1;
  assign prdata  = rdata;
  assign pslverr = psel && penable && rerr;

  always_comb begin
    next_state      = state;
    next_opt_w      = opt_w;
    next_prot_w     = prot_w;
    next_key_w      = key_w;
    next_entered    = entered;
    next_got        = got;
    next_key_access = key_access;
    next_bkd_unlock = bkd_unlock;
    next_ers_unlock = ers_unlock;
    next_rdata      = rdata;
    next_rerr       = rerr;
    case (state)
      ST_LOAD: begin
        // First edge after reset release takes the nonvolatile copies
        next_opt_w  = nv.opt & OPT_USED_MASK; // [RULE1]
        next_prot_w = nv.prot; // [RULE1]
        next_key_w  = nv.key; // [RULE2]
        next_state  = ST_RUN;
      end
      ST_RUN: begin
        if (wr && idx == IDX_CFG) begin
          if (pwdata[KEY_ACCESS_POS] && key_en) begin // [RULE3] [RULE6]
            next_key_access = 1'b1;
            next_got        = 8'h00;
          end else if (!pwdata[KEY_ACCESS_POS] && key_access) begin
            next_key_access = 1'b0;
            next_state      = ST_CMP;
          end
        end
        if (wr && idx == IDX_PROT) begin
          next_prot_w = pwdata[7:0];
        end
        if (wr && key_hit && key_access) begin
          next_entered[key_sel*8 +: 8] = pwdata[7:0];
          next_got[key_sel]            = 1'b1;
        end
      end
      ST_CMP: begin
        // Compare needs all eight bytes; partial entry simply fails
        if (key_en && (&got) && entered == key_w) begin // [RULE3] [RULE6]
          next_bkd_unlock = 1'b1;
        end
        next_got   = 8'h00;
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
    // Erase then blank verify is the only exit with the key off
    if (erase_blank_ok && state != ST_LOAD) begin
      next_ers_unlock = 1'b1; // [RULE7]
    end
    if (setup) begin
      next_rerr  = !is_mapped(idx) || (paddr[1:0] != 2'h0);
      next_rdata = 32'h0;
      case (idx)
        IDX_OPT:    next_rdata[7:0] = opt_w;
        IDX_CFG:    next_rdata[KEY_ACCESS_POS] = key_access;
        IDX_PROT:   next_rdata[7:0] = prot_w;
        IDX_NONVOLATILE_PROTECT_BYTE: next_rdata[7:0] = nv.prot;
        IDX_NONVOLATILE_OPTION_BYTE:  next_rdata[7:0] = nv.opt;
        IDX_STAT: begin
          next_rdata[ST_SEC_POS] = secured;
          next_rdata[ST_BKD_POS] = bkd_unlock;
          next_rdata[ST_ERS_POS] = ers_unlock;
        end
        default: begin
          // Key bytes read back only while unsecured
          if (key_hit && !secured) begin
            next_rdata[7:0] = key_w[key_sel*8 +: 8];
          end
        end
      endcase
      if (pwrite) begin
        // Read-only locations, and key entry from a wrong source, refuse writes
        if (is_read_only(idx)) begin
          next_rerr = 1'b1;
        end
        if ((idx == IDX_CFG || key_hit) && !key_src_ok) begin // [RULE4] [RULE5]
          next_rerr = 1'b1;
        end
        if (key_hit && !key_access) begin
          next_rerr = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_LOAD;
      opt_w      <= WORK_RST;
      prot_w     <= WORK_RST;
      key_w      <= KEY_RST;
      entered    <= 64'h0;
      got        <= 8'h00;
      key_access <= 1'b0;
      bkd_unlock <= 1'b0;
      ers_unlock <= 1'b0;
      rdata      <= 32'h0;
      rerr       <= 1'b0;
    end else begin
      state      <= next_state;
      opt_w      <= next_opt_w;
      prot_w     <= next_prot_w;
      key_w      <= next_key_w;
      entered    <= next_entered;
      got        <= next_got;
      key_access <= next_key_access;
      bkd_unlock <= next_bkd_unlock;
      ers_unlock <= next_ers_unlock;
      rdata      <= next_rdata;
      rerr       <= next_rerr;
    end
  end

  // RAM gate combines registered security with the live code_secure and bdm_master inputs
  always_comb begin
    status.secured                 = secured;
    status.ram_access_ok           = !secured || key_src_ok; // [RULE9]
    status.vector_redirect_disable = opt_w[REDIRECT_POS];
    status.flash_protect           = prot_w;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_load_work_bytes: assert property ( // [RULE1]
    state == ST_LOAD |=> opt_w == ($past(nv.opt) & OPT_USED_MASK) && prot_w == $past(nv.prot))
    else $error("working bytes not loaded");
  a_load_key_copy: assert property ( // [RULE2]
    state == ST_LOAD |=> key_w == $past(nv.key) ##1 $stable(key_w))
    else $error("key not held");
  a_key_enable_gate: assert property ( // [RULE3]
    $rose(key_access) |-> opt_w[KEY_ENABLE_POS])
    else $error("key access without enable");
  a_nonsecure_no_key: assert property ( // [RULE4]
    psel && !penable && pwrite && key_hit && !code_secure |=> $stable(entered) [*2])
    else $error("non-secure key entry");
  a_debug_no_key: assert property ( // [RULE5]
    psel && !penable && pwrite && idx == IDX_CFG && bdm_master |=> ##1 !$rose(key_access))
    else $error("debug reached key");
  a_key_off_lock: assert property ( // [RULE6]
    $rose(bkd_unlock) |-> $past(key_en) && $past(state) == ST_CMP)
    else $error("backdoor unlock with key off");
  a_erase_unlock: assert property ( // [RULE7]
    erase_blank_ok && state == ST_RUN |=> !secured && ers_unlock)
    else $error("erase verify did not unsecure");
  a_unsec_code: assert property ( // [RULE8]
    state == ST_RUN && opt_w[1:0] == SEC_UNSECURED |-> !status.secured)
    else $error("unsecured code reads secured");
  a_ram_gate: assert property ( // [RULE9]
    status.secured && bdm_master |-> !status.ram_access_ok)
    else $error("RAM open to debug");
  a_secure_default: assert property ( // [RULE10]
    opt_w[1:0] != SEC_UNSECURED && !bkd_unlock && !ers_unlock |-> status.secured)
    else $error("secured code reads unsecured");

  // Working option byte and key move only at the load edge; software cannot retarget them
  a_copies_held: assert property ( // [RULE1]
    state != ST_LOAD |=> $stable(opt_w) && $stable(key_w))
    else $error("working copies changed after load");
  a_opt_bits_masked: assert property ( // [RULE1]
    state != ST_LOAD |-> (opt_w & ~OPT_USED_MASK) == 8'h00)
    else $error("reserved option bits set");
  a_ro_write_refused: assert property ( // [RULE1]
    psel && !penable && pwrite && is_read_only(idx) |=> !(psel && penable) || pslverr)
    else $error("read-only write not refused");
  a_entry_mask_clear: assert property ( // [RULE2]
    $rose(key_access) |-> got == 8'h00)
    else $error("stale key entry mask");
  a_cmp_one_cycle: assert property ( // [RULE3]
    state == ST_CMP |=> state == ST_RUN)
    else $error("compare state stuck");
  // Unlock flags have no software clear; only reset drops them
  a_backdoor_sticky: assert property ( // [RULE3]
    bkd_unlock |=> bkd_unlock)
    else $error("backdoor unlock dropped");
  a_key_entry_refused: assert property ( // [RULE3]
    psel && !penable && pwrite && key_hit && !key_access |=> !(psel && penable) || pslverr)
    else $error("key byte taken without access");
  // Refusals are decided at setup, so they show in the access cycle
  a_nonsecure_write_refused: assert property ( // [RULE4]
    psel && !penable && pwrite && (idx == IDX_CFG || key_hit) && !code_secure |=>
      !(psel && penable) || pslverr)
    else $error("non-secure key write not refused");
  a_debug_write_refused: assert property ( // [RULE5]
    psel && !penable && pwrite && (idx == IDX_CFG || key_hit) && bdm_master |=>
      !(psel && penable) || pslverr)
    else $error("debug key write not refused");
  a_key_off_idle: assert property ( // [RULE6]
    !key_en |-> !key_access)
    else $error("key access with key disabled");
  a_erase_sticky: assert property ( // [RULE7]
    ers_unlock |=> ers_unlock)
    else $error("erase unlock dropped");
  a_erase_cause: assert property ( // [RULE7]
    $rose(ers_unlock) |-> $past(erase_blank_ok))
    else $error("erase unlock without verify");
  a_unsec_ram_open: assert property ( // [RULE8]
    !status.secured |-> status.ram_access_ok)
    else $error("RAM closed while unsecured");
  a_ram_nonsecure: assert property ( // [RULE9]
    status.secured && !code_secure |-> !status.ram_access_ok)
    else $error("RAM open to non-secure code");
  a_key_read_hidden: assert property ( // [RULE9]
    psel && !penable && !pwrite && key_hit && secured |=> prdata == 32'h0)
    else $error("key readable while secured");
  a_load_secured: assert property ( // [RULE10]
    state == ST_LOAD |-> status.secured)
    else $error("unsecured before load");
endmodule : fsol_loader

// file: fsol_far_model.sv
`timescale 1ns/1ns
// Bus-master side: flash contents, who runs code, and the erase/verify outcome
module fsol_far_model
  import fsol_pkg::*;
(
  input  wire logic pclk,
  output fsol_nv_t  nv,
  output logic      bdm_master,
  output logic      code_secure,
  output logic      erase_blank_ok
);
  initial begin
    nv             = '1;
    bdm_master     = 1'b0;
    code_secure    = 1'b1;
    erase_blank_ok = 1'b0;
  end

  task automatic set_nv(input logic [63:0] k, input logic [7:0] p, input logic [7:0] o);
    nv <= '{key: k, prot: p, opt: o};
  endtask : set_nv

  // 0 code in secure memory, 1 code in non-secure memory, 2 debug
  task automatic run_as(input logic [1:0] m);
    bdm_master  <= (m == 2'h2);
    code_secure <= (m == 2'h0);
  endtask : run_as

  // Erase and blank check reported as one pulse
  task automatic erase_verify;
    @(posedge pclk) erase_blank_ok <= 1'b1;
    @(posedge pclk) erase_blank_ok <= 1'b0;
  endtask : erase_verify
endmodule : fsol_far_model

// file: tb_flash_security_option_loader.sv
`timescale 1ns/1ns
module tb_flash_security_option_loader
  import fsol_pkg::*;
;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  fsol_nv_t          nv;
  logic              bdm_master;
  logic              code_secure;
  logic              erase_blank_ok;
  fsol_status_t      st;
  logic [9:0]        expq[$];
  logic [9:0]        e;
  logic [63:0]       key;
  logic [7:0]        opt;
  logic [7:0]        d;
  int                num_errors = 0;
  int                n_compared = 0;

  always #5 pclk = ~pclk;

  fsol_far_model far (.pclk(pclk), .nv(nv), .bdm_master(bdm_master),
                      .code_secure(code_secure), .erase_blank_ok(erase_blank_ok));
  fsol_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                   .pready(pready), .pslverr(pslverr), .nv(nv), .bdm_master(bdm_master),
                   .code_secure(code_secure), .erase_blank_ok(erase_blank_ok), .status(st));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Queue entry: read flag, expected byte, expected refusal
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd,
                      input logic [7:0] exp, input logic err);
    expq.push_back({~w, exp, err});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = expq.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[0]});
      if (e[9]) cmp(prdata, {24'h0, e[8:1]});
    end
  end

  task automatic chk_st(input logic sec, input logic ram_ok);
    cmp({30'h0, st.secured, st.ram_access_ok}, {30'h0, sec, ram_ok});
  endtask : chk_st

  task automatic do_reset;
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  // Full key entry walk; ce/ke are the expected refusals of config and key writes
  task automatic backdoor(input logic [63:0] k, input logic ce, input logic ke);
    xfer(1'b1, IDX_CFG, 8'h20, 8'h00, ce);
    for (int i = 0; i < KEY_BYTES; i++) xfer(1'b1, IDX_KEY + 16'(i), k[8*i+:8], 8'h00, ke);
    xfer(1'b1, IDX_CFG, 8'h00, 8'h00, ce);
    repeat (3) @(posedge pclk);
  endtask : backdoor

  task automatic summarize;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  initial begin
    #100000;
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(32'h9283));
    key = {$urandom, $urandom};
    far.run_as(2'h2);
    for (int c = 0; c < 4; c++) begin
      opt = {1'b1, 1'($urandom), 4'h5, 2'(c)};
      d   = 8'($urandom);
      far.set_nv(key, d, opt);
      do_reset();
      xfer(1'b0, IDX_OPT, 8'h00, opt & OPT_USED_MASK, 1'b0);
      xfer(1'b0, IDX_PROT, 8'h00, d, 1'b0);
      xfer(1'b0, IDX_NONVOLATILE_OPTION_BYTE, 8'h00, opt, 1'b0);
      chk_st(c != 2, c == 2);
      cmp({23'h0, st.vector_redirect_disable, st.flash_protect}, {23'h0, opt[6], d});
    end
    $display("done: security codes");
    far.run_as(2'h0);
    d = 8'($urandom);
    xfer(1'b1, IDX_PROT, d, 8'h00, 1'b0);
    xfer(1'b0, IDX_PROT, 8'h00, d, 1'b0);
    cmp({24'h0, st.flash_protect}, {24'h0, d});
    xfer(1'b1, IDX_OPT, 8'h00, 8'h00, 1'b1);
    xfer(1'b0, 16'h1822, 8'h00, 8'h00, 1'b1);
    $display("done: register access");
    far.run_as(2'h2);
    backdoor(key, 1'b1, 1'b1);
    chk_st(1'b1, 1'b0);
    far.run_as(2'h1);
    backdoor(key, 1'b1, 1'b1);
    chk_st(1'b1, 1'b0);
    far.run_as(2'h0);
    backdoor(key ^ 64'h1, 1'b0, 1'b0);
    chk_st(1'b1, 1'b1);
    xfer(1'b0, IDX_KEY, 8'h00, 8'h00, 1'b0);
    backdoor(key, 1'b0, 1'b0);
    chk_st(1'b0, 1'b1);
    xfer(1'b0, IDX_STAT, 8'h00, 8'(1 << ST_BKD_POS), 1'b0);
    xfer(1'b0, IDX_KEY + 16'h3, 8'h00, key[31:24], 1'b0);
    $display("done: backdoor key");
    far.set_nv(key, 8'hff, 8'h43);
    do_reset();
    backdoor(key, 1'b0, 1'b1);
    chk_st(1'b1, 1'b1);
    xfer(1'b0, IDX_CFG, 8'h00, 8'h00, 1'b0);
    far.erase_verify();
    repeat (2) @(posedge pclk);
    chk_st(1'b0, 1'b1);
    xfer(1'b0, IDX_STAT, 8'h00, 8'(1 << ST_ERS_POS), 1'b0);
    $display("done: key disabled and erase");
    summarize();
  end
endmodule : tb_flash_security_option_loader
